// ### osc_trim_pkg.sv
package osc_trim_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_INITIAL_TRIM  = 8'h0b;
	localparam logic [7:0] ADDR_COLD_COEFF    = 8'h0c;
	localparam logic [7:0] ADDR_COMP_CONTROL  = 8'h0d;
	localparam logic [7:0] ADDR_TRIM_STATUS   = 8'h20;
	localparam logic [7:0] ADDR_TEMP_AVG      = 8'h21;

	// Reset values.
	localparam logic [7:0] RESET_INITIAL_TRIM = 8'h00;
	localparam logic [7:0] RESET_COLD_COEFF   = 8'h00;
	localparam logic [7:0] RESET_COMP_CONTROL = 8'h00;

	// Field positions.
	localparam int DIG_TRIM_MSB  = 7;
	localparam int DIG_TRIM_LSB  = 6;
	localparam int ANA_TRIM_MSB  = 5;
	localparam int TEMP_SENSE_BIT  = 7;
	localparam int BATT_SENSE_BIT  = 6;
	localparam int BATT_RATE_BIT   = 5;
	localparam int GAIN_MSB        = 4;

	// Analog trim offset is this centre minus the code.
	localparam logic signed [6:0] ANA_TRIM_CENTER = 7'sh20;

	// Digital trim codes, offsets in half-ppm units.
	localparam logic [1:0] DT_DISABLED = 2'h0;
	localparam logic [1:0] DT_PLUS     = 2'h1;
	localparam logic [1:0] DT_ZERO     = 2'h2;
	localparam logic [1:0] DT_MINUS    = 2'h3;
	localparam logic signed [7:0] DT_STEP_HALF_PPM = 8'sh3d;

	// Timing.
	localparam longint CLK_HZ          = 125000000;
	localparam longint CONV_TIME_MS    = 22;
	localparam longint CONV_CYCLES     = CLK_HZ * CONV_TIME_MS / 1000;
	localparam longint PERIOD_SLOW_S   = 600;
	localparam longint PERIOD_FAST_S   = 60;
	localparam longint SLOW_CYCLES     = CLK_HZ * PERIOD_SLOW_S;
	localparam longint FAST_CYCLES     = CLK_HZ * PERIOD_FAST_S;
	localparam int     CONV_PER_CYCLE  = 2;

	// Sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_CONV1 = 4'b0010,
		ST_CONV2 = 4'b0100,
		ST_WAIT  = 4'b1000
	} seq_state_t;

endpackage

// ### trim_decode.sv
`timescale 1ns/1ns
module trim_decode (
	// Trim codes.
	input  wire logic [1:0]        i_digital_trim,
	input  wire logic [5:0]        i_analog_trim,
	// Decoded offsets.
	output logic signed [6:0]      o_analog_ppm,
	output logic signed [7:0]      o_digital_half_ppm,
	output logic                   o_digital_enabled
);
	import osc_trim_pkg::*;

	// Analog offset is centre minus unsigned code: 0 gives +32, 63 gives -31.
	assign o_analog_ppm = ANA_TRIM_CENTER - signed'({1'b0, i_analog_trim});

	// Coarse digital trim in half-ppm units.
	always_comb begin
		o_digital_enabled = 1'b1;
		unique case (i_digital_trim)
			DT_DISABLED: begin
				o_digital_half_ppm = 8'sh00;
				o_digital_enabled  = 1'b0;
			end
			DT_PLUS:  o_digital_half_ppm = DT_STEP_HALF_PPM;
			DT_ZERO:  o_digital_half_ppm = 8'sh00;
			DT_MINUS: o_digital_half_ppm = -DT_STEP_HALF_PPM;
		endcase
	end
endmodule

// ### interval_timer.sv
`timescale 1ns/1ns
module interval_timer #(
	parameter longint LIMIT = 10
) (
	// Clock and reset.
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	// Control.
	input  wire logic i_run,
	// Pulse on expiry.
	output logic      o_tick
);
	logic [39:0] count_r;

	// Counts while running, pulses and restarts at the limit.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count_r <= 40'h0;
			o_tick  <= 1'b0;
		end else if (!i_run) begin
			count_r <= 40'h0;
			o_tick  <= 1'b0;
		end else if (count_r == 40'(LIMIT - 1)) begin
			count_r <= 40'h0;
			o_tick  <= 1'b1;
		end else begin
			count_r <= count_r + 40'h1;
			o_tick  <= 1'b0;
		end
	end
endmodule

// ### osc_trim_temp_comp_config.sv
// Overview of operation
// - Six-bit analog trim spans +32 to -31 ppm in 1 ppm steps.
// - Analog offset equals 32 minus the unsigned code.
// - Initial trim register at 0Bh: digital trim 7:6, analog trim 5:0.
// - Enabling sensing makes compensation use the newly loaded values.
// - Cold coefficient register at 0Ch holds an 8-bit unsigned magnitude.
// - Control at 0Dh: sense enable 7, battery enable 6, rate 5, gain 4:0.
// - Sense enable resets to 0, disabling sensor, converter and auto trim.
// - With sensing disabled only the initial trim values steer frequency.
// - Setting sense enable starts a cycle ending after two conversions.
// - The average of the two conversions is stored as the result.
// - Digital trim: 00 off, 01 +30.5, 10 zero, 11 -30.5 ppm.
// - Battery sensing every 10 minutes at rate 0, 1 minute at 1; off if disabled.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module osc_trim_temp_comp_config #(
	parameter longint CONV_CYC = osc_trim_pkg::CONV_CYCLES,
	parameter longint SLOW_CYC = osc_trim_pkg::SLOW_CYCLES,
	parameter longint FAST_CYC = osc_trim_pkg::FAST_CYCLES
) (
	// Clock and reset.
	input  wire logic              i_core_clk,
	input  wire logic              i_rstn,
	// Register port.
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic [7:0]             o_rdata,
	// Power and sensor interface.
	input  wire logic              i_battery_mode,
	input  wire logic [9:0]        i_temp_sample,
	// Trim outputs to the oscillator.
	output logic signed [6:0]      o_analog_ppm,
	output logic signed [7:0]      o_digital_half_ppm,
	output logic                   o_digital_enabled,
	output logic [7:0]             o_active_coeff,
	output logic [4:0]             o_active_gain,
	// Sensor control and result.
	output logic                   o_sensor_on,
	output logic                   o_conv_start,
	output logic                   o_cycle_done,
	output logic [9:0]             o_temp_avg
);
	import osc_trim_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers and synchronisers.

	logic [7:0]  initial_trim_setting_r;
	logic [7:0]  cold_curvature_coeff_r;
	logic [7:0]  comp_control_gain_r;
	logic [7:0]  active_trim_r;
	logic        batt_sync1_r;
	logic        batt_sync2_r;
	logic        cycle_req_r;
	logic        tse_prev_r;
	seq_state_t  state_r;
	logic [31:0] conv_cnt_r;
	logic [9:0]  first_sample_r;
	logic        temp_sense_enable;
	logic        battery_sense_enable;
	logic        battery_sense_rate;
	logic        slow_tick;
	logic        fast_tick;
	logic        periodic_run;
	logic [10:0] sample_sum;
	logic signed [6:0] dec_analog;
	logic signed [7:0] dec_digital;
	logic              dec_dig_en;

	assign temp_sense_enable    = comp_control_gain_r[TEMP_SENSE_BIT];
	assign battery_sense_enable = comp_control_gain_r[BATT_SENSE_BIT];
	assign battery_sense_rate   = comp_control_gain_r[BATT_RATE_BIT];

	// Battery mode pin passes two flops before use.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			batt_sync1_r <= 1'b0;
			batt_sync2_r <= 1'b0;
		end else begin
			batt_sync1_r <= i_battery_mode;
			batt_sync2_r <= batt_sync1_r;
		end
	end

	// Software writes; control resets with sensing disabled.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			initial_trim_setting_r <= RESET_INITIAL_TRIM;
			cold_curvature_coeff_r <= RESET_COLD_COEFF;
			comp_control_gain_r    <= RESET_COMP_CONTROL;
		end else if (i_wr) begin
			unique case (i_addr)
				ADDR_INITIAL_TRIM: initial_trim_setting_r <= i_wdata;
				ADDR_COLD_COEFF:   cold_curvature_coeff_r <= i_wdata;
				ADDR_COMP_CONTROL: comp_control_gain_r    <= i_wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, no side effects.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				ADDR_INITIAL_TRIM: o_rdata <= initial_trim_setting_r;
				ADDR_COLD_COEFF:   o_rdata <= cold_curvature_coeff_r;
				ADDR_COMP_CONTROL: o_rdata <= comp_control_gain_r;
				ADDR_TRIM_STATUS:  o_rdata <= {4'h0, state_r};
				ADDR_TEMP_AVG:     o_rdata <= o_temp_avg[9:2];
				default:           o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trim values handed to the oscillator.

	// Shadow copies are taken while sensing is off, so enabling uses new values.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			active_trim_r  <= RESET_INITIAL_TRIM;
			o_active_coeff <= RESET_COLD_COEFF;
			o_active_gain  <= 5'h00;
		end else if (!temp_sense_enable) begin
			active_trim_r  <= initial_trim_setting_r;
			o_active_coeff <= cold_curvature_coeff_r;
			o_active_gain  <= comp_control_gain_r[GAIN_MSB:0];
		end
	end

	trim_decode u_decode (
		.i_digital_trim     (active_trim_r[DIG_TRIM_MSB:DIG_TRIM_LSB]),
		.i_analog_trim      (active_trim_r[ANA_TRIM_MSB:0]),
		.o_analog_ppm       (dec_analog),
		.o_digital_half_ppm (dec_digital),
		.o_digital_enabled  (dec_dig_en)
	);

	// Decoded offsets registered onto the outputs.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_analog_ppm       <= ANA_TRIM_CENTER;
			o_digital_half_ppm <= 8'sh00;
			o_digital_enabled  <= 1'b0;
		end else begin
			o_analog_ppm       <= dec_analog;
			o_digital_half_ppm <= dec_digital;
			o_digital_enabled  <= dec_dig_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cycle requests: enable edge, and periodic in battery mode.

	assign periodic_run = temp_sense_enable & battery_sense_enable & batt_sync2_r;

	interval_timer #(.LIMIT(SLOW_CYC)) u_slow (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_run      (periodic_run & ~battery_sense_rate),
		.o_tick     (slow_tick)
	);

	interval_timer #(.LIMIT(FAST_CYC)) u_fast (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_run      (periodic_run & battery_sense_rate),
		.o_tick     (fast_tick)
	);

	// Pending request; a new request wins over the clear on acceptance.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tse_prev_r  <= 1'b0;
			cycle_req_r <= 1'b0;
		end else begin
			tse_prev_r <= temp_sense_enable;
			if (temp_sense_enable & ~tse_prev_r) begin
				cycle_req_r <= 1'b1;
			end else if (slow_tick | fast_tick) begin
				cycle_req_r <= 1'b1;
			end else if (!temp_sense_enable | (state_r == ST_IDLE && cycle_req_r)) begin
				cycle_req_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer: two conversions, then average.

	assign sample_sum = {1'b0, first_sample_r} + {1'b0, i_temp_sample};

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r        <= ST_IDLE;
			conv_cnt_r     <= 32'h0;
			first_sample_r <= 10'h000;
			o_temp_avg     <= 10'h000;
			o_conv_start   <= 1'b0;
			o_cycle_done   <= 1'b0;
			o_sensor_on    <= 1'b0;
		end else begin
			o_conv_start <= 1'b0;
			o_cycle_done <= 1'b0;
			if (!temp_sense_enable) begin
				state_r     <= ST_IDLE;
				o_sensor_on <= 1'b0;
				conv_cnt_r  <= 32'h0;
			end else begin
				unique case (state_r)
					ST_IDLE: begin
						if (cycle_req_r) begin
							state_r      <= ST_CONV1;
							o_conv_start <= 1'b1;
							o_sensor_on  <= 1'b1;
							conv_cnt_r   <= 32'h0;
						end
					end
					ST_CONV1: begin
						if (conv_cnt_r == 32'(CONV_CYC - 1)) begin
							first_sample_r <= i_temp_sample;
							conv_cnt_r     <= 32'h0;
							o_conv_start   <= 1'b1;
							state_r        <= ST_CONV2;
						end else begin
							conv_cnt_r <= conv_cnt_r + 32'h1;
						end
					end
					ST_CONV2: begin
						if (conv_cnt_r == 32'(CONV_CYC - 1)) begin
							o_temp_avg   <= sample_sum[10:1];
							o_cycle_done <= 1'b1;
							o_sensor_on  <= 1'b0;
							conv_cnt_r   <= 32'h0;
							state_r      <= ST_WAIT;
						end else begin
							conv_cnt_r <= conv_cnt_r + 32'h1;
						end
					end
					ST_WAIT: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// ### osc_trim_checker.sv
`timescale 1ns/1ns
module osc_trim_checker #(
	parameter longint CONV_CYC = 4
) (
	// Clock, reset and register port.
	input  wire logic              i_core_clk,
	input  wire logic              i_rstn,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic [7:0]        o_rdata,
	// Trim and sensor outputs.
	input  wire logic signed [6:0] o_analog_ppm,
	input  wire logic signed [7:0] o_digital_half_ppm,
	input  wire logic              o_digital_enabled,
	input  wire logic [7:0]        o_active_coeff,
	input  wire logic [4:0]        o_active_gain,
	input  wire logic              o_sensor_on,
	input  wire logic              o_conv_start,
	input  wire logic              o_cycle_done
);
	logic [7:0]  trim_r;
	logic [7:0]  coef_r;
	logic [7:0]  ctl_r;
	logic [7:0]  exp_rd;
	logic [15:0] cnt_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	// Coarse digital code to half-ppm offset.
	function automatic logic signed [7:0] dig_half(input logic [1:0] c);
		return (c == 2'h1) ? 8'sh3d : (c == 2'h3) ? -8'sh3d : 8'sh00;
	endfunction

	// Mirror of the three registers as software wrote them.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			trim_r <= 8'h00;
			coef_r <= 8'h00;
			ctl_r <= 8'h00;
		end else if (i_wr) begin
			if (i_addr == 8'h0b) trim_r <= i_wdata;
			if (i_addr == 8'h0c) coef_r <= i_wdata;
			if (i_addr == 8'h0d) ctl_r <= i_wdata;
		end
	end

	// Cycles since the last conversion start.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= o_conv_start ? 16'h0000 : cnt_r + 16'h0001;
		end
	end

	// Value a read of the current address must return.
	always_comb begin
		case (i_addr)
			8'h0b: exp_rd = trim_r;
			8'h0c: exp_rd = coef_r;
			8'h0d: exp_rd = ctl_r;
			default: exp_rd = 8'h00;
		endcase
	end

	read_back_a: assert property (
		i_rd && i_addr[7:1] != 7'h10 |=> o_rdata == $past(exp_rd))
		else $error("read data differs from the written register");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data present without a read");
	ana_decode_a: assert property (
		i_wr && i_addr == 8'h0b && !ctl_r[7] ##1 !i_wr [*2]
		|=> o_analog_ppm == 7'sd32 - $signed({1'b0, $past(i_wdata[5:0], 3)}))
		else $error("analog offset wrong");
	dig_decode_a: assert property (
		i_wr && i_addr == 8'h0b && !ctl_r[7] ##1 !i_wr [*2]
		|=> o_digital_half_ppm == dig_half($past(i_wdata[7:6], 3))
		&& o_digital_enabled == ($past(i_wdata[7:6], 3) != 2'h0))
		else $error("digital offset wrong");
	shadow_freeze_a: assert property (ctl_r[7] && $past(ctl_r[7])
		|-> $stable(o_active_coeff) && $stable(o_active_gain))
		else $error("coefficient changed while sensing");
	conv_begin_a: assert property (
		$rose(ctl_r[7]) |-> ##[1:3] (o_conv_start && o_sensor_on))
		else $error("no conversion after enable");
	conv_space_a: assert property ((o_conv_start && $past(o_sensor_on)) || o_cycle_done
		|-> cnt_r == CONV_CYC - 1)
		else $error("conversion spacing wrong");
	pulse_width_a: assert property (o_conv_start || o_cycle_done
		|=> !o_conv_start && !o_cycle_done)
		else $error("pulse longer than one cycle");
	sense_off_a: assert property (!ctl_r[7] [*3] |-> !o_sensor_on && !o_conv_start)
		else $error("sensor active while disabled");
endmodule

bind osc_trim_temp_comp_config osc_trim_checker #(.CONV_CYC(CONV_CYC)) chk_u (
	.i_core_clk         (i_core_clk),
	.i_rstn             (i_rstn),
	.i_addr             (i_addr),
	.i_wdata            (i_wdata),
	.i_wr               (i_wr),
	.i_rd               (i_rd),
	.o_rdata            (o_rdata),
	.o_analog_ppm       (o_analog_ppm),
	.o_digital_half_ppm (o_digital_half_ppm),
	.o_digital_enabled  (o_digital_enabled),
	.o_active_coeff     (o_active_coeff),
	.o_active_gain      (o_active_gain),
	.o_sensor_on        (o_sensor_on),
	.o_conv_start       (o_conv_start),
	.o_cycle_done       (o_cycle_done)
);

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
	import osc_trim_pkg::*;
	logic              i_core_clk = 1'b0;
	logic              i_rstn = 1'b0;
	logic [7:0]        i_addr = 8'h00;
	logic [7:0]        i_wdata = 8'h00;
	logic              i_wr = 1'b0;
	logic              i_rd = 1'b0;
	logic              i_battery_mode = 1'b0;
	logic [9:0]        i_temp_sample = 10'h000;
	logic [7:0]        o_rdata;
	logic signed [6:0] o_analog_ppm;
	logic signed [7:0] o_digital_half_ppm;
	logic              o_digital_enabled;
	logic [7:0]        o_active_coeff;
	logic [4:0]        o_active_gain;
	logic              o_sensor_on;
	logic              o_conv_start;
	logic              o_cycle_done;
	logic [9:0]        o_temp_avg;
	int                bad_count = 0;
	int                checks_done = 0;
	int                n;

	osc_trim_temp_comp_config #(.CONV_CYC(4), .SLOW_CYC(50), .FAST_CYC(20)) dut_u (
		.i_core_clk         (i_core_clk),
		.i_rstn             (i_rstn),
		.i_addr             (i_addr),
		.i_wdata            (i_wdata),
		.i_wr               (i_wr),
		.i_rd               (i_rd),
		.o_rdata            (o_rdata),
		.i_battery_mode     (i_battery_mode),
		.i_temp_sample      (i_temp_sample),
		.o_analog_ppm       (o_analog_ppm),
		.o_digital_half_ppm (o_digital_half_ppm),
		.o_digital_enabled  (o_digital_enabled),
		.o_active_coeff     (o_active_coeff),
		.o_active_gain      (o_active_gain),
		.o_sensor_on        (o_sensor_on),
		.o_conv_start       (o_conv_start),
		.o_cycle_done       (o_cycle_done),
		.o_temp_avg         (o_temp_avg)
	);

	// Free-running core clock.
	initial forever #4 i_core_clk = ~i_core_clk;

	////////////////////////////////////////////////////////////////////////
	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	// One-cycle register read; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk($sformatf("read %h", a), exp, o_rdata);
	endtask

	// Waits for conversion start (sel 0) or cycle done (sel 1), at most lim cycles.
	task automatic wait_hi(input bit sel, input int lim);
		n = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			n++;
		end while ((sel ? o_cycle_done : o_conv_start) !== 1'b1 && n < lim);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge i_core_clk);
		bad_count++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////
	// Test sequence.
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		rd(8'h0b, 8'h00);
		rd(8'h0d, 8'h00);
		rd(ADDR_TRIM_STATUS, {4'h0, ST_IDLE});
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		wr(8'h0c, 8'hc6);
		rd(8'h0c, 8'hc6);
		rd(8'h0c, 8'hc6);
		$display("test registers done");
		// Every analog code but the highest, with a rotating digital code.
		for (int i = 0; i < 63; i++) begin
			wr(8'h0b, {i[1:0], i[5:0]});
			repeat (3) @(posedge i_core_clk);
			#1 chk("analog", 32 - i, o_analog_ppm);
			chk("digital", i[0] ? (i[1] ? -61 : 61) : 0, o_digital_half_ppm);
			chk("dig on", i[1:0] != 0, o_digital_enabled);
		end
		rd(8'h0b, 8'hbe);
		$display("test trim decode done");
		// Load new values with sensing off, then enable and run one cycle.
		// The hot-side coefficient lives outside this block.
		wr(8'h0c, 8'h46);
		wr(8'h0d, 8'h13);
		i_temp_sample <= 10'h3ff;
		wr(8'h0d, 8'h93);
		#1 chk("coeff", 8'h46, o_active_coeff);
		chk("gain", 5'h13, o_active_gain);
		wait_hi(1'b0, 8);
		chk("enable to start", 2, n);
		wait_hi(1'b0, 8);
		chk("start spacing", 4, n);
		repeat (2) @(posedge i_core_clk);
		i_temp_sample <= 10'h001;
		wait_hi(1'b1, 12);
		chk("cycle done", 1'b1, o_cycle_done);
		chk("average", 10'h200, o_temp_avg);
		rd(ADDR_TEMP_AVG, 8'h80);
		wr(8'h0d, 8'h13);
		$display("test conversion done");
		// Periodic sensing on battery at the slow and the fast rate.
		i_battery_mode <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			wr(8'h0d, r ? 8'he0 : 8'hc0);
			wait_hi(1'b1, 40);
			wait_hi(1'b1, 90);
			chk("period", 1'b1, n >= (r ? 18 : 48) && n <= (r ? 32 : 62));
			wr(8'h0d, 8'h00);
		end
		// No periodic sensing with battery sensing off, or off battery.
		for (int k = 0; k < 2; k++) begin
			i_battery_mode <= k[0];
			wr(8'h0d, k ? 8'ha0 : 8'he0);
			wait_hi(1'b1, 40);
			wait_hi(1'b1, 80);
			chk("no periodic", 80, n);
			wr(8'h0d, 8'h00);
		end
		$display("test battery sensing done");
		wrap_up();
	end
endmodule
